// ==== src/lcd_decoder.sv ====
/*
  Command/address bus decoder: two-edge capture, field extraction, pairing of halves.
  Assumes cs, cke and ca are synchronous to mclk and clk_restart is a one-cycle pulse.
*/
`timescale 1ns/1ps
module lcd_decoder #(
  parameter int RESTART_CYC = lcd_pkg::RESTART_CYC
) (
  input  wire logic           mclk,
  input  wire logic           arst_n,
  input  wire logic           cke,
  input  wire logic           cs,
  input  wire logic [5:0]     ca,
  input  wire logic           bl_otf_en,
  input  wire logic           bl_fixed32,
  input  wire logic           clk_restart,
  output lcd_pkg::lcd_op_t    cmd,
  output logic                cmd_valid,
  output logic [2:0]          bank,
  output logic                all_banks,
  output logic                auto_pre,
  output logic                burst32,
  output logic [13:0]         row,
  output logic [9:0]          col,
  output logic [5:0]          mr_addr,
  output logic [7:0]          mr_op,
  output logic                illegal,
  output logic                illegal_seen,
  output logic                ready
);
  import lcd_pkg::*;

  localparam int CW = $clog2(RESTART_CYC + 1);

  typedef enum logic {PH_FIRST = 1'b0, PH_SECOND = 1'b1} lcd_phase_t;

  lcd_trk_if trk ();

  lcd_pair_tracker u_trk (
    .mclk   (mclk),
    .arst_n (arst_n),
    .t      (trk)
  );

  lcd_phase_t      state,      next_state;
  logic [5:0]      r1_ca,      next_r1_ca;
  logic [2:0]      hold_bank,  next_hold_bank;
  logic            hold_ap,    next_hold_ap;
  logic            hold_bl,    next_hold_bl;
  logic            hold_c9,    next_hold_c9;
  logic [3:0]      hold_row,   next_hold_row;
  logic [5:0]      hold_ma,    next_hold_ma;
  logic            hold_op7,   next_hold_op7;
  logic [CW-1:0]   rcnt,       next_rcnt;
  lcd_op_t         next_cmd;
  logic            next_cmd_valid;
  logic [2:0]      next_bank;
  logic            next_all_banks;
  logic            next_auto_pre;
  logic            next_burst32;
  logic [13:0]     next_row;
  logic [9:0]      next_col;
  logic [5:0]      next_mr_addr;
  logic [7:0]      next_mr_op;
  logic            next_illegal;
  logic            next_illegal_seen;
  logic            next_ready;
  lcd_kind_t       kind;
  logic            err;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_state        = state;
    next_r1_ca        = r1_ca;
    next_hold_bank    = hold_bank;
    next_hold_ap      = hold_ap;
    next_hold_bl      = hold_bl;
    next_hold_c9      = hold_c9;
    next_hold_row     = hold_row;
    next_hold_ma      = hold_ma;
    next_hold_op7     = hold_op7;
    next_cmd          = OP_NONE;
    next_cmd_valid    = 1'h0;
    next_bank         = bank;
    next_all_banks    = all_banks;
    next_auto_pre     = auto_pre;
    next_burst32      = burst32;
    next_row          = row;
    next_col          = col;
    next_mr_addr      = mr_addr;
    next_mr_op        = mr_op;
    kind              = lcd_classify(r1_ca);
    err               = 1'h0;
    trk.step          = 1'h0;
    trk.gap           = 1'h0;
    trk.accept        = 1'h0;
    trk.kind          = kind;

    // Device cannot see the clock stop itself, so the restart is signalled
    if (clk_restart) begin
      next_rcnt = CW'(RESTART_CYC);
    end else if (rcnt != '0) begin
      next_rcnt = rcnt - CW'(1);
    end else begin
      next_rcnt = rcnt;
    end

    case (state)
      PH_FIRST: begin
        if (cke && cs) begin
          next_r1_ca = ca;
          next_state = PH_SECOND;
        end else begin
          trk.gap = 1'h1;
        end
      end
      PH_SECOND: begin
        next_state = PH_FIRST;
        trk.step   = 1'h1;
        // Second edge must see select low and enable high; gated until restart settles
        err = !ready || cs || !cke;
        case (kind)
          K_PRE, K_REF: begin
            if (!err) begin
              next_cmd       = (kind == K_PRE) ? OP_PRE : OP_REF;
              next_all_banks = r1_ca[CA_FLAG];
              next_bank      = r1_ca[CA_FLAG] ? 3'h0 : ca[2:0];
            end
          end
          K_SRE, K_SRX: begin
            next_cmd = (kind == K_SRE) ? OP_SRE : OP_SRX;
          end
          K_MPC: begin
            if (!err) begin
              next_cmd   = OP_MPC;
              next_mr_op = {1'h0, r1_ca[CA_FLAG], ca};
            end
          end
          K_WR1, K_MWR1, K_RD1: begin
            if (kind == K_MWR1 && r1_ca[CA_FLAG]) begin
              err = 1'h1;
            end
            next_hold_bank = ca[2:0];
            next_hold_c9   = ca[CA_C9];
            next_hold_ap   = ca[CA_AP];
            next_hold_bl   = r1_ca[CA_FLAG];
          end
          K_MRR1: begin
            next_hold_ma = ca;
          end
          K_MRW1: begin
            next_hold_ma  = ca;
            next_hold_op7 = r1_ca[CA_FLAG];
          end
          K_ACT1: begin
            next_hold_bank = ca[2:0];
            next_hold_row  = {r1_ca[CA_R13], r1_ca[CA_R12], ca[CA_R11], ca[CA_R10]};
          end
          K_CAS2: begin
            if (!trk.second_ok) begin
              err = 1'h1;
            end else if ((trk.pend == K_WR1 || trk.pend == K_MWR1) && ca[1:0] != 2'h0) begin
              err = 1'h1;
            end else if (!err) begin
              case (trk.pend)
                K_WR1, K_MWR1, K_RD1: begin
                  next_col      = {hold_c9, r1_ca[CA_FLAG], ca, 2'h0};
                  next_cmd      = (trk.pend == K_WR1) ? OP_WR :
                                  (trk.pend == K_MWR1) ? OP_MWR : OP_RD;
                  next_bank     = hold_bank;
                  next_all_banks = 1'h0;
                  next_auto_pre = hold_ap;
                  // Masked writes are fixed at 16
                  next_burst32  = (trk.pend == K_MWR1) ? 1'h0 :
                                  (bl_otf_en ? hold_bl : bl_fixed32);
                end
                K_MRR1: begin
                  next_cmd     = OP_MRR;
                  next_mr_addr = hold_ma;
                end
                default: next_cmd = OP_NONE;
              endcase
            end
          end
          K_ACT2: begin
            if (!trk.second_ok) begin
              err = 1'h1;
            end else if (!err) begin
              next_cmd       = OP_ACT;
              next_bank      = hold_bank;
              next_all_banks = 1'h0;
              next_row       = {hold_row, r1_ca[5:2], ca};
            end
          end
          K_MRW2: begin
            if (!trk.second_ok) begin
              err = 1'h1;
            end else if (!err) begin
              next_cmd     = OP_MRW;
              next_mr_addr = hold_ma;
              next_mr_op   = {hold_op7, r1_ca[CA_FLAG], ca};
            end
          end
          default: begin
            err = 1'h1;
          end
        endcase
        if (err) begin
          next_cmd = OP_NONE;
        end
        trk.accept = !err;
      end
      default: next_state = PH_FIRST;
    endcase

    next_cmd_valid    = (next_cmd != OP_NONE);
    next_illegal      = err || trk.abandon;
    // Sticky until reset: the device needs a full restart after misuse
    next_illegal_seen = illegal_seen || next_illegal;
    next_ready        = (next_rcnt == '0);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= PH_FIRST;
      r1_ca        <= 6'h00;
      hold_bank    <= 3'h0;
      hold_ap      <= 1'h0;
      hold_bl      <= 1'h0;
      hold_c9      <= 1'h0;
      hold_row     <= 4'h0;
      hold_ma      <= 6'h00;
      hold_op7     <= 1'h0;
      rcnt         <= CW'(RESTART_CYC);
      cmd          <= OP_NONE;
      cmd_valid    <= 1'h0;
      bank         <= 3'h0;
      all_banks    <= 1'h0;
      auto_pre     <= 1'h0;
      burst32      <= 1'h0;
      row          <= 14'h0000;
      col          <= 10'h000;
      mr_addr      <= 6'h00;
      mr_op        <= 8'h00;
      illegal      <= 1'h0;
      illegal_seen <= 1'h0;
      ready        <= 1'h0;
    end else begin
      state        <= next_state;
      r1_ca        <= next_r1_ca;
      hold_bank    <= next_hold_bank;
      hold_ap      <= next_hold_ap;
      hold_bl      <= next_hold_bl;
      hold_c9      <= next_hold_c9;
      hold_row     <= next_hold_row;
      hold_ma      <= next_hold_ma;
      hold_op7     <= next_hold_op7;
      rcnt         <= next_rcnt;
      cmd          <= next_cmd;
      cmd_valid    <= next_cmd_valid;
      bank         <= next_bank;
      all_banks    <= next_all_banks;
      auto_pre     <= next_auto_pre;
      burst32      <= next_burst32;
      row          <= next_row;
      col          <= next_col;
      mr_addr      <= next_mr_addr;
      mr_op        <= next_mr_op;
      illegal      <= next_illegal;
      illegal_seen <= next_illegal_seen;
      ready        <= next_ready;
    end
  end

endmodule // lcd_decoder

// ==== pkg/lcd_pkg.sv ====
/*
  Shared constants, types and decode helpers for the command/address bus decoder.
  Assumes one clock (mclk) on which the CA bus is sampled at each rising edge.
*/
// Functional notes
// - After restart, normal commands only after 2 clocks plus power-down exit delay.
// - Commands take two edges, opcode on first with select high; deselect one cycle.
// - Valid fields driven; self-refresh entry/exit codes; four codes are reserved.
// - Precharge and refresh carry all-bank flag on line 5, bank on second edge.
// - All-bank flag applies operation to every bank, else only the addressed bank.
// - Masked write-1 requires line 5 low and burst length 16 only.
// - Auto-precharge bit schedules precharge of the addressed bank after access.
// - On-the-fly burst bit selects 32 high, 16 low; else driven but unused.
// - Column second half carries C8 and C7..C2; C1:0 zero; writes need C3:2 low.
package lcd_pkg;

  // ==========================================================================
  // Command kinds and decoded operations
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_MPC  = 4'h1, K_PRE  = 4'h2, K_REF  = 4'h3,
    K_SRE  = 4'h4, K_SRX  = 4'h5, K_WR1  = 4'h6, K_MWR1 = 4'h7,
    K_RD1  = 4'h8, K_CAS2 = 4'h9, K_MRW1 = 4'hA, K_MRW2 = 4'hB,
    K_MRR1 = 4'hC, K_ACT1 = 4'hD, K_ACT2 = 4'hE, K_RSV  = 4'hF
  } lcd_kind_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_MPC = 4'h1, OP_PRE = 4'h2, OP_REF = 4'h3,
    OP_SRE  = 4'h4, OP_SRX = 4'h5, OP_WR  = 4'h6, OP_MWR = 4'h7,
    OP_RD   = 4'h8, OP_MRW = 4'h9, OP_MRR = 4'hA, OP_ACT = 4'hB
  } lcd_op_t;

  // ==========================================================================
  // First-edge codes, CA4..CA0 packed as bits 4..0
  localparam logic [4:0] CODE_MPC  = 5'h00;
  localparam logic [4:0] CODE_PRE  = 5'h10;
  localparam logic [4:0] CODE_REF  = 5'h08;
  localparam logic [4:0] CODE_SRE  = 5'h18;
  localparam logic [4:0] CODE_WR1  = 5'h04;
  localparam logic [4:0] CODE_SRX  = 5'h14;
  localparam logic [4:0] CODE_MWR1 = 5'h0C;
  localparam logic [4:0] CODE_RD1  = 5'h02;
  localparam logic [4:0] CODE_CAS2 = 5'h12;
  localparam logic [4:0] CODE_MRW1 = 5'h06;
  localparam logic [4:0] CODE_MRW2 = 5'h16;
  localparam logic [4:0] CODE_MRR1 = 5'h0E;
  localparam logic [1:0] CODE_ACT1 = 2'h1;
  localparam logic [1:0] CODE_ACT2 = 2'h3;

  // ==========================================================================
  // Field positions on the CA bus
  localparam int CA_FLAG = 5;  // AB, BL, OP7, OP6, C8 on first edge
  localparam int CA_AP   = 5;
  localparam int CA_C9   = 4;
  localparam int CA_R10  = 4;
  localparam int CA_R11  = 5;
  localparam int CA_R12  = 2;
  localparam int CA_R13  = 3;

  // ==========================================================================
  // Restart timing at 125 MHz
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int TXP_MIN_PS      = 7500;
  localparam int TXP_MIN_NCK     = 5;
  localparam int RESTART_NCK     = 2;
  localparam int TXP_PS_CYC      = (TXP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TXP_CYC         = (TXP_PS_CYC > TXP_MIN_NCK) ? TXP_PS_CYC : TXP_MIN_NCK;
  localparam int RESTART_CYC     = RESTART_NCK + TXP_CYC;

  function automatic lcd_kind_t lcd_classify(input logic [5:0] r1);
    lcd_kind_t k;
    k = K_RSV;
    if (r1[1:0] == CODE_ACT1) begin
      k = K_ACT1;
    end else if (r1[1:0] == CODE_ACT2) begin
      k = K_ACT2;
    end else begin
      case (r1[4:0])
        CODE_MPC:  k = K_MPC;
        CODE_PRE:  k = K_PRE;
        CODE_REF:  k = K_REF;
        CODE_SRE:  k = K_SRE;
        CODE_WR1:  k = K_WR1;
        CODE_SRX:  k = K_SRX;
        CODE_MWR1: k = K_MWR1;
        CODE_RD1:  k = K_RD1;
        CODE_CAS2: k = K_CAS2;
        CODE_MRW1: k = K_MRW1;
        CODE_MRW2: k = K_MRW2;
        CODE_MRR1: k = K_MRR1;
        default:   k = K_RSV;
      endcase
    end
    return k;
  endfunction

endpackage

// ==== pkg/lcd_trk_if.sv ====
/*
  Carrier between the decoder and its pairing tracker.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface lcd_trk_if;
  import lcd_pkg::*;
  logic      step;
  logic      gap;
  logic      accept;
  lcd_kind_t kind;
  lcd_kind_t pend;
  logic      second_ok;
  logic      abandon;

  modport dec (output step, gap, accept, kind, input pend, second_ok, abandon);
  modport trk (input step, gap, accept, kind, output pend, second_ok, abandon);
endinterface // lcd_trk_if

// ==== src/lcd_pair_tracker.sv ====
/*
  Remembers the last first-half command and judges whether the next one pairs.
  Assumes step marks a second-edge cycle and gap marks a deselect cycle.
*/
`timescale 1ns/1ps
module lcd_pair_tracker (
  input wire logic mclk,
  input wire logic arst_n,
  lcd_trk_if.trk   t
);
  import lcd_pkg::*;

  lcd_kind_t pend;
  lcd_kind_t next_pend;

  function automatic logic is_first(input lcd_kind_t k);
    return (k == K_WR1) || (k == K_MWR1) || (k == K_RD1) || (k == K_MRR1) ||
           (k == K_ACT1) || (k == K_MRW1) || (k == K_MPC);
  endfunction

  // ==========================================================================
  // Pairing
  function automatic logic pairs(input lcd_kind_t p, input lcd_kind_t k);
    case (k)
      K_CAS2:  return (p == K_WR1) || (p == K_MWR1) || (p == K_RD1) ||
                      (p == K_MRR1) || (p == K_MPC);
      K_ACT2:  return p == K_ACT1;
      K_MRW2:  return p == K_MRW1;
      default: return 1'h0;
    endcase
  endfunction

  // Multi-purpose may stand alone, so only the others can be abandoned
  assign t.second_ok = pairs(pend, t.kind);
  assign t.abandon   = (pend != K_NONE) && (pend != K_MPC) &&
                       (t.gap || (t.step && !pairs(pend, t.kind)));
  assign t.pend      = pend;

  always_comb begin
    next_pend = pend;
    if (t.step) begin
      next_pend = (t.accept && is_first(t.kind)) ? t.kind : K_NONE;
    end else if (t.gap) begin
      next_pend = K_NONE;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= K_NONE;
    end else begin
      pend <= next_pend;
    end
  end

endmodule // lcd_pair_tracker

// ==== verif/lcd_ctrl_model.sv ====
/* Model memory controller driving select and the command/address lines.
   Assumes the bench calls its tasks from one process. */
`timescale 1ns/1ps
module lcd_ctrl_model (
  input  wire logic       mclk,
  output logic            cke,
  output logic            cs,
  output logic [5:0]      ca
);
  // ==========
  // Bus drive
  initial begin
    cke = 1'b1;
    cs = 1'b0;
    ca = 6'h15;
  end
  // Idle lines keep toggling so a stale value never decodes
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      cs <= 1'b0;
      ca <= ~ca;
    end
  endtask
  task automatic send(input logic [5:0] r1, input logic [5:0] r2);
    @(posedge mclk);
    cs <= 1'b1;
    ca <= r1;
    @(posedge mclk);
    cs <= 1'b0;
    ca <= r2;
  endtask
  // Enable dropped on the second edge, a misuse the decoder must refuse
  task automatic send_low_cke(input logic [5:0] r1, input logic [5:0] r2);
    send(r1, r2);
    cke <= 1'b0;
    @(posedge mclk);
    cke <= 1'b1;
  endtask
endmodule // lcd_ctrl_model

// ==== verif/lcd_decoder_asserts.sv ====
/* Concurrent checks on the decoder ports, bound into lcd_decoder.
   Assumes one clock domain and the decoder's restart count. */
`timescale 1ns/1ps
module lcd_decoder_asserts #(
  parameter int RESTART_CYC = lcd_pkg::RESTART_CYC
) (
  input wire logic             mclk,
  input wire logic             arst_n,
  input wire logic             cke,
  input wire logic             cs,
  input wire logic [5:0]       ca,
  input wire logic             bl_otf_en,
  input wire logic             bl_fixed32,
  input wire logic             clk_restart,
  input wire lcd_pkg::lcd_op_t cmd,
  input wire logic             cmd_valid,
  input wire logic [2:0]       bank,
  input wire logic             all_banks,
  input wire logic             auto_pre,
  input wire logic             burst32,
  input wire logic [13:0]      row,
  input wire logic [9:0]       col,
  input wire logic             illegal,
  input wire logic             illegal_seen,
  input wire logic             ready
);
  import lcd_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Cycles since restart
  logic [7:0] rcnt;
  logic [7:0] next_rcnt;
  always_comb begin
    next_rcnt = rcnt;
    if (clk_restart) begin
      next_rcnt = 8'h00;
    end else if (rcnt != 8'(RESTART_CYC)) begin
      next_rcnt = rcnt + 8'h01;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rcnt <= 8'h00;
    end else begin
      rcnt <= next_rcnt;
    end
  end
  // ==========
  // Command shapes
  sequence s_first_rsv;
    ready && cke && cs && !$past(cs) && ca[4:0] inside {5'h1C, 5'h0A, 5'h1A, 5'h1E};
  endsequence
  // Nothing pending: no select-high edge two edges back
  sequence s_first_orphan;
    ready && cke && cs && !$past(cs) && !$past(cs, 2)
      && (ca[4:0] == 5'h12 || ca[4:0] == 5'h16 || ca[1:0] == 2'b11);
  endsequence
  sequence s_second;
    !cs && cke;
  endsequence
  sequence s_first_any;
    ready && cke && cs && !$past(cs);
  endsequence
  sequence s_second_nocke;
    !cs && !cke;
  endsequence
  // ==========
  // Checks
  chk_rsv_flag: assert property (s_first_rsv ##1 s_second |=> illegal)
    else $error("reserved code not flagged");
  chk_orphan_flag: assert property (s_first_orphan ##1 s_second |=> illegal)
    else $error("orphan second half not flagged");
  chk_cke_refuse: assert property (s_first_any ##1 s_second_nocke |=> illegal)
    else $error("second edge without enable not flagged");
  chk_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd_valid longer than one cycle");
  chk_cmd_edges: assert property (
    cmd_valid |-> $past(cs, 2) && !$past(cs) && $past(cke) && $past(ready))
    else $error("result without two-edge cause");
  chk_bank_op: assert property (
    cmd_valid && cmd inside {OP_PRE, OP_REF} |-> all_banks == $past(ca[5], 2)
      && bank == (all_banks ? 3'h0 : $past(ca[2:0])))
    else $error("bank operation fields wrong");
  chk_col_fields: assert property (
    cmd_valid && cmd inside {OP_WR, OP_MWR, OP_RD} |-> auto_pre == $past(ca[5], 3)
      && bank == $past(ca[2:0], 3) && (cmd == OP_RD || col[3:2] == 2'b00)
      && col == {$past(ca[4], 3), $past(ca[5], 2), $past(ca), 2'b00})
    else $error("column access fields wrong");
  chk_burst_len: assert property (
    cmd_valid && cmd inside {OP_WR, OP_MWR, OP_RD} |-> (cmd != OP_MWR || !$past(ca[5], 4))
      && burst32 == (cmd != OP_MWR && ($past(bl_otf_en) ? $past(ca[5], 4) : $past(bl_fixed32))))
    else $error("burst length wrong");
  chk_act_row: assert property (
    cmd_valid && cmd == OP_ACT |-> bank == $past(ca[2:0], 3)
      && row == {$past(ca[3:2], 4), $past(ca[5:4], 3), $past(ca[5:2], 2), $past(ca)})
    else $error("activate row wrong");
  chk_ready_wait: assert property (ready == (rcnt == 8'(RESTART_CYC)))
    else $error("ready out of step with restart wait");
  chk_seen_sticky: assert property (illegal || illegal_seen |=> illegal_seen)
    else $error("illegal_seen not held");
endmodule // lcd_decoder_asserts

bind lcd_decoder lcd_decoder_asserts #(.RESTART_CYC(RESTART_CYC)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .cke(cke), .cs(cs), .ca(ca), .bl_otf_en(bl_otf_en),
  .bl_fixed32(bl_fixed32), .clk_restart(clk_restart), .cmd(cmd), .cmd_valid(cmd_valid),
  .bank(bank), .all_banks(all_banks), .auto_pre(auto_pre), .burst32(burst32), .row(row),
  .col(col), .illegal(illegal), .illegal_seen(illegal_seen), .ready(ready));

// ==== verif/test_lpddr_command_bus_decoder.sv ====
/* Bench for lcd_decoder: a controller model drives the bus, a queue model
   predicts each answer. Assumes the default restart count. */
`timescale 1ns/1ps
module test_lpddr_command_bus_decoder;
  import lcd_pkg::*;
  typedef struct {
    logic ill; lcd_op_t op; logic [2:0] bk; logic ab, ap, b32;
    logic [13:0] row; logic [9:0] col; logic [5:0] ma; logic [7:0] mo;
  } lcd_exp_t;
  logic        mclk, arst_n, bl_otf_en, bl_fixed32, clk_restart, cke, cs;
  logic [5:0]  ca, mr_addr;
  lcd_op_t     cmd;
  logic        cmd_valid, all_banks, auto_pre, burst32, illegal, illegal_seen, ready;
  logic [2:0]  bank;
  logic [13:0] row, rw;
  logic [9:0]  col, c;
  logic [7:0]  mr_op;
  logic [5:0]  badc [8] = '{6'h1C, 6'h0A, 6'h1A, 6'h1E, 6'h12, 6'h16, 6'h0F, 6'h2C};
  lcd_exp_t    m, r, z;
  lcd_exp_t    q[$];
  int          err_total, checks, cyc, i;
  logic        clk_run = 1'b1;
  lcd_decoder dut (
    .mclk(mclk), .arst_n(arst_n), .cke(cke), .cs(cs), .ca(ca), .bl_otf_en(bl_otf_en),
    .bl_fixed32(bl_fixed32), .clk_restart(clk_restart), .cmd(cmd), .cmd_valid(cmd_valid),
    .bank(bank), .all_banks(all_banks), .auto_pre(auto_pre), .burst32(burst32), .row(row),
    .col(col), .mr_addr(mr_addr), .mr_op(mr_op), .illegal(illegal),
    .illegal_seen(illegal_seen), .ready(ready));
  lcd_ctrl_model ctl (.mclk(mclk), .cke(cke), .cs(cs), .ca(ca));
  initial begin
    mclk = 1'b0;
    forever begin
      #4;
      if (clk_run) begin
        mclk = ~mclk;
      end
    end
  end
  // ==========
  // Checking
  task automatic chk_v(input string n, input logic [13:0] x, input logic [13:0] g);
    checks++;
    if (g !== x) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic chk_op(input lcd_op_t x, input lcd_op_t g);
    checks++;
    if (g !== x) begin
      err_total++;
      $display("ERROR cmd expected %0d seen %0d", x, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      report_and_stop;
    end
  end
  always @(negedge mclk) begin
    if (cmd_valid === 1'b1 || illegal === 1'b1) begin
      r = z;
      if (q.size() > 0) begin
        r = q.pop_front();
      end
      chk_v("illegal", 14'(r.ill), 14'(illegal));
      chk_v("cmd_valid", 14'(!r.ill), 14'(cmd_valid));
      if (!r.ill) begin
        chk_op(r.op, cmd);
        chk_v("bank", 14'(r.bk), 14'(bank));
        chk_v("all_banks", 14'(r.ab), 14'(all_banks));
        chk_v("auto_pre", 14'(r.ap), 14'(auto_pre));
        chk_v("burst32", 14'(r.b32), 14'(burst32));
        chk_v("row", r.row, row);
        chk_v("col", 14'(r.col), 14'(col));
        chk_v("mr_addr", 14'(r.ma), 14'(mr_addr));
        chk_v("mr_op", 14'(r.mo), 14'(mr_op));
      end
    end
  end
  // ==========
  // Stimulus
  task automatic put(input lcd_op_t op);
    m.ill = 1'b0;
    m.op = op;
    q.push_back(m);
  endtask
  task automatic bad;
    lcd_exp_t e;
    e = m;
    e.ill = 1'b1;
    q.push_back(e);
  endtask
  task automatic wait_ready;
    for (int k = 0; k < 20 && ready !== 1'b1; k++) begin
      @(negedge mclk);
    end
    chk_v("ready", 14'h1, 14'(ready));
  endtask
  task automatic bank_op(input logic rf, input logic ab, input logic [2:0] b);
    ctl.send({ab, ~rf, rf, 3'h0}, {3'($urandom), b});
    m.ab = ab;
    m.bk = ab ? 3'h0 : b;
    put(rf ? OP_REF : OP_PRE);
  endtask
  task automatic col_op(input logic [4:0] code, input logic bl, input lcd_op_t op);
    m.bk = 3'($urandom);
    m.ap = 1'($urandom);
    c = 10'($urandom) & ((op == OP_RD) ? 10'h3FC : 10'h3F0);
    ctl.send({bl, code}, {m.ap, c[9], 1'($urandom), m.bk});
    ctl.send({c[8], 5'h12}, c[7:2]);
    m.ab = 1'b0;
    m.col = c;
    m.b32 = (op != OP_MWR) && (bl_otf_en ? bl : bl_fixed32);
    put(op);
  endtask
  initial begin
    z = '{1'b0, OP_NONE, 3'h0, 1'b0, 1'b0, 1'b0, 14'h0, 10'h0, 6'h0, 8'h0};
    m = z;
    arst_n = 1'b0;
    bl_otf_en = 1'b0;
    bl_fixed32 = 1'b0;
    clk_restart = 1'b0;
    void'($urandom(28645));
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    wait_ready;
    for (i = 0; i < 16; i++) begin
      bank_op(i[0], i[1], 3'($urandom));
    end
    $display("test bank_ops done");
    for (i = 0; i < 12; i++) begin
      @(posedge mclk);
      bl_otf_en <= i[0];
      bl_fixed32 <= i[1];
      col_op(5'h04, 1'($urandom), OP_WR);
      col_op(5'h0C, 1'b0, OP_MWR);
      col_op(5'h02, 1'($urandom), OP_RD);
    end
    $display("test column_ops done");
    for (i = 0; i < 8; i++) begin
      rw = 14'($urandom);
      m.bk = 3'($urandom);
      ctl.send({2'($urandom), rw[13:12], 2'b01}, {rw[11:10], 1'($urandom), m.bk});
      ctl.send({rw[9:6], 2'b11}, rw[5:0]);
      m.row = rw;
      m.ab = 1'b0;
      put(OP_ACT);
      m.ma = 6'($urandom);
      m.mo = 8'($urandom);
      ctl.send({m.mo[7], 5'h06}, m.ma);
      ctl.send({m.mo[6], 5'h16}, m.mo[5:0]);
      put(OP_MRW);
      m.ma = 6'($urandom);
      ctl.send({1'($urandom), 5'h0E}, m.ma);
      ctl.send({1'($urandom), 5'h12}, 6'($urandom));
      put(OP_MRR);
      ctl.send({1'($urandom), 5'h18}, 6'($urandom));
      put(OP_SRE);
      ctl.send({1'($urandom), 5'h14}, 6'($urandom));
      put(OP_SRX);
      m.mo = {1'b0, 7'($urandom)};
      ctl.send({m.mo[6], 5'h00}, m.mo[5:0]);
      put(OP_MPC);
      ctl.send({1'($urandom), 5'h12}, 6'($urandom));
      ctl.idle(2);
    end
    $display("test mode_ops done");
    for (i = 0; i < 8; i++) begin
      ctl.send(badc[i], 6'($urandom));
      bad;
      ctl.idle(1);
    end
    ctl.send(6'h04, 6'($urandom));
    bad;
    ctl.idle(1);
    ctl.send(6'h04, 6'($urandom));
    ctl.send(6'h12, {4'($urandom), 2'b01});
    bad;
    ctl.send_low_cke(6'h10, 6'($urandom));
    bad;
    ctl.idle(3);
    @(negedge mclk);
    chk_v("illegal_seen", 14'h1, 14'(illegal_seen));
    $display("test illegal_ops done");
    bank_op(1'b1, 1'b0, 3'($urandom));
    ctl.idle(4);
    // Park the clock low with select low, then restart it
    @(negedge mclk);
    clk_run = 1'b0;
    #38;
    clk_run = 1'b1;
    @(posedge mclk);
    clk_restart <= 1'b1;
    @(posedge mclk);
    clk_restart <= 1'b0;
    ctl.send(6'h10, 6'($urandom));
    bad;
    ctl.idle(1);
    wait_ready;
    bank_op(1'b0, 1'b0, 3'($urandom));
    ctl.idle(3);
    @(posedge mclk);
    arst_n <= 1'b0;
    @(negedge mclk);
    chk_v("illegal_seen", 14'h0, 14'(illegal_seen));
    chk_v("ready", 14'h0, 14'(ready));
    m = z;
    @(posedge mclk);
    arst_n <= 1'b1;
    wait_ready;
    bank_op(1'b1, 1'b1, 3'($urandom));
    ctl.idle(4);
    chk_v("pending", 14'h0, 14'(q.size()));
    $display("test restart_reset done");
    report_and_stop;
  end
endmodule // test_lpddr_command_bus_decoder
